// >>> bench/rmd_core_props.sv
// assertions on the ports of the decode core
`timescale 1ns/1ps
module rmd_core_props (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [7:0] opcode,
	input wire logic opcode_valid,
	input wire logic [15:0] operand,
	input wire logic busy,
	input wire logic done,
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	input wire logic [7:0] acc,
	input wire logic [7:0] index_reg,
	input wire logic [4:0] condition_flags_register
);
	logic take;
	logic [4:0] cnt;
	logic [4:0] want;
	logic [7:0] acc_in;
	logic is_compare;
	assign take = opcode_valid && clk_en && !busy;
	// zero means an opcode whose length is not tracked here
	function automatic logic [4:0] cyc_of(input logic [7:0] op);
		if (op == 8'h42) return 5'h0b;
		if (!(op[3:0] inside {4'h1, 4'h2, 4'h5, 4'h8, 4'h9})) return 5'h00;
		case (op[7:4])
			4'ha: return 5'h02;
			4'hb, 4'hf: return 5'h03;
			4'hc, 4'he: return 5'h04;
			4'hd: return 5'h05;
			default: return 5'h00;
		endcase
	endfunction : cyc_of
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt <= 5'h00;
			want <= 5'h00;
			acc_in <= 8'h00;
			is_compare <= 1'b0;
		end else if (take) begin
			cnt <= 5'h01;
			want <= cyc_of(opcode);
			acc_in <= acc;
			is_compare <= opcode[3:0] == 4'h1 && opcode[7:4] >= 4'ha;
		end else if (cnt != 5'h1f) begin
			cnt <= cnt + 5'h01;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_CYCLES: assert property (done && want != 5'h00 |-> cnt == want)
		else $error("done at wrong cycle count");
	AST_PRODUCT_LAT: assert property (take && opcode == 8'h42 |-> ##10 !done ##1 done)
		else $error("multiply length wrong");
	AST_PRODUCT_BUSY: assert property (take && opcode == 8'h42 |=> busy [*8])
		else $error("multiply not busy");
	AST_PRODUCT_VALUE: assert property (take && opcode == 8'h42 |->
		##11 {index_reg, acc} == $past(index_reg, 11) * $past(acc, 11))
		else $error("product wrong");
	AST_PRODUCT_FLAGS: assert property (take && opcode == 8'h42 |-> ##11
		condition_flags_register[4] == 1'b0 && condition_flags_register[0] == 1'b0
		&& condition_flags_register[3:1] == $past(condition_flags_register[3:1], 11))
		else $error("multiply flags wrong");
	AST_COMPARE_KEEP: assert property (done && is_compare |-> acc == acc_in)
		else $error("compare changed acc");
	AST_FETCH_DIR: assert property (take && opcode[7:4] == 4'hb && opcode[3:0] < 4'h7
		|=> mem_rd && mem_addr == {8'h00, $past(operand[7:0])})
		else $error("direct fetch wrong");
	AST_FETCH_EXT: assert property (take && opcode[7:4] == 4'hc && opcode[3:0] < 4'h7
		|=> mem_rd && mem_addr == $past(operand))
		else $error("extended fetch wrong");
	AST_FETCH_IX: assert property (take && opcode[7:4] == 4'hf && opcode[3:0] < 4'h7
		|=> mem_rd && mem_addr == {8'h00, $past(index_reg)})
		else $error("indexed fetch wrong");
endmodule : rmd_core_props

// >>> bench/rmd_mem_model.sv
// far-side memory: answers a read within its fetch cycle only
`timescale 1ns/1ps
module rmd_mem_model (
	input wire logic ref_clk,
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	output logic [7:0] mem_rdata,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata
);
	logic [7:0] store [0:255];
	logic [7:0] last = 8'h00;
	initial begin
		for (int i = 0; i < 256; i++) store[i] = 8'(i) ^ 8'h5a;
	end
	// off the fetch cycle the bus toggles, so a late sample cannot pass
	assign mem_rdata = mem_rd ? store[mem_addr[7:0]] : ~last;
	always @(posedge ref_clk) begin
		last <= mem_rdata;
		if (mem_wr) store[mem_addr[7:0]] <= mem_wdata;
	end
endmodule : rmd_mem_model

// >>> bench/tb.sv
// testbench for the register/memory and multiply decode core
`timescale 1ns/1ps
module tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] opcode = 8'h00;
	logic opcode_valid = 1'b0;
	logic [15:0] operand = 16'h0000;
	logic clk_en = 1'b1;
	logic busy, done, illegal, mem_rd, mem_wr, jump_taken, call_taken, jt, ct, wr;
	logic [1:0] op_bytes;
	logic [15:0] mem_addr, jump_target;
	logic [7:0] mem_rdata, mem_wdata, acc, index_reg;
	logic [4:0] condition_flags_register;
	logic [3:0] fn_codes [5] = '{4'h5, 4'h2, 4'h8, 4'h1, 4'h9};
	logic [3:0] modes [6] = '{4'ha, 4'hb, 4'hc, 4'hf, 4'he, 4'hd};
	logic [15:0] args [6] = '{16'h0055, 16'h0030, 16'h1234, 16'h0000, 16'h0020, 16'h1200};
	logic [15:0] eas [6] = '{16'h0000, 16'h0030, 16'h1234, 16'h0010, 16'h0030, 16'h1210};
	int cycs [6] = '{2, 3, 4, 3, 4, 5};
	int lens [6] = '{2, 2, 3, 1, 2, 3};
	int bad_count = 0;
	int checks_done = 0;
	always #50 ref_clk = ~ref_clk;
	rmd_core DUT (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .opcode(opcode),
		.opcode_valid(opcode_valid), .operand(operand), .busy(busy), .done(done),
		.illegal(illegal), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .jump_taken(jump_taken),
		.call_taken(call_taken), .jump_target(jump_target), .op_bytes(op_bytes), .acc(acc),
		.index_reg(index_reg), .condition_flags_register(condition_flags_register));
	rmd_mem_model MEM (.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata));
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude
	// one instruction; counts edges from the taking edge to done
	task automatic op(input logic [7:0] code, input logic [15:0] arg, input int cyc,
		input logic [15:0] ea);
		int n;
		logic [15:0] a;
		@(posedge ref_clk);
		opcode <= code;
		operand <= arg;
		opcode_valid <= 1'b1;
		@(posedge ref_clk);
		opcode_valid <= 1'b0;
		n = 0;
		#1;
		while (n == 0 || done !== 1'b1) begin
			if (mem_rd === 1'b1) a = mem_addr;
			if (n == 40) begin
				bad_count++;
				conclude();
			end
			@(posedge ref_clk);
			n++;
			#1;
		end
		jt = jump_taken;
		ct = call_taken;
		wr = mem_wr;
		// done shows just after the last cycle's edge, so the length is one edge more
		chk("cycles", 16'(cyc), 16'(n + 1));
		if (code[7:4] > 4'ha && code[3:0] < 4'h7) chk("address", ea, a);
	endtask : op
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		chk("flags", 16'h0008, 16'(condition_flags_register));
		op(8'ha6, 16'h0008, 2, 16'h0000);
		op(8'hae, 16'h0010, 2, 16'h0000);
		op(8'ha9, 16'h0008, 2, 16'h0000);
		chk("acc", 16'h0010, 16'(acc));
		chk("half", 16'h0001, 16'(condition_flags_register[4]));
		foreach (fn_codes[i]) foreach (modes[j]) begin
			op({modes[j], fn_codes[i]}, args[j], cycs[j], eas[j]);
			chk("bytes", 16'(lens[j]), 16'(op_bytes));
		end
		op(8'ha6, 16'h00c8, 2, 16'h0000);
		op(8'hae, 16'h00fa, 2, 16'h0000);
		op(8'ha1, 16'h00ff, 2, 16'h0000);
		chk("acc", 16'h00c8, 16'(acc));
		chk("carry", 16'h0001, 16'(condition_flags_register[0]));
		op(8'h42, 16'h0000, 11, 16'h0000);
		chk("product", 16'hc350, {index_reg, acc});
		chk("flags", 16'h000c, 16'(condition_flags_register));
		op(8'ha8, 16'h00ff, 2, 16'h0000);
		chk("acc", 16'h00af, 16'(acc));
		op(8'ha1, 16'h00ff, 2, 16'h0000);
		op(8'ha2, 16'h000f, 2, 16'h0000);
		chk("acc", 16'h009f, 16'(acc));
		op(8'hbc, 16'h0044, 2, 16'h0000);
		chk("jumped", 16'h0001, 16'(jt));
		chk("target", 16'h0044, jump_target);
		op(8'hcd, 16'h1abc, 6, 16'h0000);
		chk("called", 16'h0001, 16'(ct));
		chk("target", 16'h1abc, jump_target);
		chk("acc", 16'h009f, 16'(acc));
		op(8'hb7, 16'h0040, 4, 16'h0000);
		chk("store strobe", 16'h0001, 16'(wr));
		chk("store data", 16'h009f, 16'(mem_wdata));
		op(8'ha6, 16'h0000, 2, 16'h0000);
		op(8'hb6, 16'h0040, 3, 16'h0040);
		chk("acc", 16'h009f, 16'(acc));
		@(posedge ref_clk);
		opcode <= 8'h00;
		opcode_valid <= 1'b1;
		@(posedge ref_clk);
		opcode_valid <= 1'b0;
		#1;
		chk("illegal", 16'h0001, 16'(illegal));
		// with the enable low a valid request must not start anything
		@(posedge ref_clk);
		clk_en <= 1'b0;
		opcode <= 8'ha6;
		operand <= 16'h0033;
		opcode_valid <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		chk("frozen busy", 16'h0000, 16'(busy));
		chk("frozen acc", 16'h009f, 16'(acc));
		@(posedge ref_clk);
		opcode_valid <= 1'b0;
		clk_en <= 1'b1;
		conclude();
	end
endmodule : tb
bind rmd_core rmd_core_props PROPS (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
	.opcode(opcode), .opcode_valid(opcode_valid), .operand(operand), .busy(busy),
	.done(done), .mem_addr(mem_addr), .mem_rd(mem_rd), .acc(acc), .index_reg(index_reg),
	.condition_flags_register(condition_flags_register));

// >>> logic/rmd_core.sv
// register/memory and multiply execution core
//
// Overview of operation
// [RL1] multiply X by A into 16 bits, 11 cycles
// [RL2] product high byte to X, low to A
// [RL3] multiply clears H and C, keeps I N Z
// [RL4] bit test opcodes, bytes and cycles per mode
// [RL5] subtract with borrow opcodes and cycle counts
// [RL6] add with carry opcodes and byte counts
// [RL7] exclusive or opcodes and cycle counts
// [RL8] compare opcodes; updates flags only
// [RL9] register operand, memory operand by mode
// [RL10] jumps use no register, only address
// [RL11] half carry from bit 3 on adds
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "rmd_defines.svh"
module rmd_core import rmd_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [7:0] opcode,
	input wire logic opcode_valid,
	input wire logic [15:0] operand,
	output logic busy,
	output logic done,
	output logic illegal,
	output logic [15:0] mem_addr,
	output logic mem_rd,
	input wire logic [7:0] mem_rdata,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	output logic jump_taken,
	output logic call_taken,
	output logic [15:0] jump_target,
	output logic [1:0] op_bytes,
	output logic [7:0] acc,
	output logic [7:0] index_reg,
	output logic [4:0] condition_flags_register
);
	typedef enum logic [1:0] {RMD_IDLE, RMD_FETCH, RMD_WAIT} rmd_state_t;

	rmd_decode_t dec;
	rmd_decode_t cur;
	rmd_state_t state;
	logic [3:0] cnt;
	logic [7:0] opnd;
	logic [15:0] ea;
	logic [15:0] next_ea;
	logic [7:0] reg_op;
	logic [8:0] sum;
	logic [7:0] res;
	logic carry_out;
	logic half;
	logic [15:0] product;

	rmd_opcode_table u_table (
		.opcode(opcode),
		.info(dec)
	);

	// effective address from the addressing mode
	always_comb begin
		unique case (dec.mode)
			RMD_AM_DIR: next_ea = {8'h00, operand[7:0]};
			RMD_AM_EXT: next_ea = operand;
			RMD_AM_IX: next_ea = {8'h00, index_reg};
			RMD_AM_IX1: next_ea = 16'(operand[7:0]) + 16'(index_reg);
			RMD_AM_IX2: next_ea = operand + 16'(index_reg);
			default: next_ea = 16'h0000;
		endcase
	end

	assign busy = (state != RMD_IDLE);
	assign reg_op = cur.use_x ? index_reg : acc; // [RL9]
	assign product = 16'(index_reg) * 16'(acc); // [RL1]

	always_comb begin
		sum = 9'h000;
		half = 1'b0;
		res = 8'h00;
		carry_out = 1'b0;
		unique case (cur.alu)
			RMD_ALU_ADD, RMD_ALU_ADC: begin
				sum = {1'b0, reg_op} + {1'b0, opnd} +
					9'(cur.alu == RMD_ALU_ADC && condition_flags_register[`RMD_FLAG_C]);
				half = (reg_op[3:0] + opnd[3:0] + 4'(cur.alu == RMD_ALU_ADC &&
					condition_flags_register[`RMD_FLAG_C])) < reg_op[3:0] ||
					((5'(reg_op[3:0]) + 5'(opnd[3:0]) + 5'(cur.alu == RMD_ALU_ADC &&
					condition_flags_register[`RMD_FLAG_C])) > 5'h0f); // [RL11]
				res = sum[7:0];
				carry_out = sum[8];
			end
			RMD_ALU_SUB, RMD_ALU_SUBTRACT_WITH_BORROW, RMD_ALU_COMPARE_ACCUMULATOR: begin
				sum = {1'b0, reg_op} - {1'b0, opnd} -
					9'(cur.alu == RMD_ALU_SUBTRACT_WITH_BORROW &&
					condition_flags_register[`RMD_FLAG_C]);
				res = sum[7:0];
				carry_out = sum[8];
			end
			RMD_ALU_AND, RMD_ALU_BIT: res = reg_op & opnd;
			RMD_ALU_ORA: res = reg_op | opnd;
			RMD_ALU_EXCLUSIVE_OR: res = reg_op ^ opnd;
			RMD_ALU_LD: res = opnd;
			RMD_ALU_ST: res = reg_op;
			default: res = 8'h00;
		endcase
	end

	// sequencing: the instruction holds busy from the taking edge, one cycle less than its documented cycle count
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= RMD_IDLE;
			cur <= '0;
			cnt <= 4'h0;
			ea <= 16'h0000;
			op_bytes <= 2'h0;
		end else if (clk_en) begin
			unique case (state)
				RMD_IDLE: begin
					if (opcode_valid && dec.valid) begin
						cur <= dec;
						ea <= next_ea;
						cnt <= dec.cycles - 4'h1;
						// instruction length, so the fetch side knows how far to step
						op_bytes <= dec.bytes; // [RL6]
						state <= (dec.mode == RMD_AM_INH || dec.mode == RMD_AM_IMM ||
							dec.alu == RMD_ALU_UNCONDITIONAL_JUMP ||
							dec.alu == RMD_ALU_SUBROUTINE_CALL ||
							dec.alu == RMD_ALU_ST) ? RMD_WAIT : RMD_FETCH;
					end
				end
				RMD_FETCH: begin
					cnt <= cnt - 4'h1;
					state <= RMD_WAIT;
				end
				RMD_WAIT: begin
					if (cnt > 4'h1)
						cnt <= cnt - 4'h1;
					else
						state <= RMD_IDLE;
				end
				default: state <= RMD_IDLE;
			endcase
		end
	end

	// memory operand capture; immediate comes straight from the operand byte
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			opnd <= 8'h00;
		else if (clk_en) begin
			if (state == RMD_IDLE && opcode_valid && dec.mode == RMD_AM_IMM)
				opnd <= operand[7:0]; // [RL9]
			else if (state == RMD_FETCH)
				opnd <= mem_rdata; // [RL9]
		end
	end

	assign mem_rd = (state == RMD_FETCH);
	assign mem_addr = ea;

	logic finish;
	assign finish = (state == RMD_WAIT) && (cnt <= 4'h1);

	// register and flag writeback at the last cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			acc <= 8'h00;
			index_reg <= 8'h00;
			condition_flags_register <= `RMD_FLAGS_RESET;
		end else if (clk_en && finish) begin
			unique case (cur.alu)
				RMD_ALU_UNSIGNED_PRODUCT: begin
					index_reg <= product[15:8]; // [RL2]
					acc <= product[7:0]; // [RL2]
					condition_flags_register[`RMD_FLAG_H] <= 1'b0; // [RL3]
					condition_flags_register[`RMD_FLAG_C] <= 1'b0; // [RL3]
				end
				RMD_ALU_ADD, RMD_ALU_ADC: begin
					acc <= res;
					condition_flags_register[`RMD_FLAG_H] <= half; // [RL11]
					condition_flags_register[`RMD_FLAG_C] <= carry_out;
					condition_flags_register[`RMD_FLAG_N] <= res[7];
					condition_flags_register[`RMD_FLAG_Z] <= (res == 8'h00);
				end
				RMD_ALU_SUB, RMD_ALU_SUBTRACT_WITH_BORROW, RMD_ALU_COMPARE_ACCUMULATOR: begin
					// compare leaves the register alone
					if (cur.alu != RMD_ALU_COMPARE_ACCUMULATOR)
						acc <= res; // [RL5]
					condition_flags_register[`RMD_FLAG_C] <= carry_out; // [RL8]
					condition_flags_register[`RMD_FLAG_N] <= res[7];
					condition_flags_register[`RMD_FLAG_Z] <= (res == 8'h00);
				end
				RMD_ALU_AND, RMD_ALU_ORA, RMD_ALU_EXCLUSIVE_OR, RMD_ALU_BIT, RMD_ALU_LD: begin
					if (cur.alu == RMD_ALU_LD && cur.use_x)
						index_reg <= res;
					else if (cur.alu != RMD_ALU_BIT)
						acc <= res; // [RL7]
					condition_flags_register[`RMD_FLAG_N] <= res[7]; // [RL4]
					condition_flags_register[`RMD_FLAG_Z] <= (res == 8'h00);
				end
				RMD_ALU_ST: begin
					condition_flags_register[`RMD_FLAG_N] <= res[7];
					condition_flags_register[`RMD_FLAG_Z] <= (res == 8'h00);
				end
				default: ;
			endcase
		end
	end

	// one-cycle completion and side outputs, held in flip-flops
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			done <= 1'b0;
			illegal <= 1'b0;
			mem_wr <= 1'b0;
			mem_wdata <= 8'h00;
			jump_taken <= 1'b0;
			call_taken <= 1'b0;
			jump_target <= 16'h0000;
		end else if (clk_en) begin
			done <= finish;
			illegal <= (state == RMD_IDLE) && opcode_valid && !dec.valid;
			mem_wr <= finish && (cur.alu == RMD_ALU_ST);
			mem_wdata <= res;
			jump_taken <= finish && (cur.alu == RMD_ALU_UNCONDITIONAL_JUMP); // [RL10]
			call_taken <= finish && (cur.alu == RMD_ALU_SUBROUTINE_CALL); // [RL10]
			if (finish)
				jump_target <= ea; // [RL10]
		end
	end
endmodule : rmd_core

// >>> logic/rmd_opcode_table.sv
// opcode table: addressing mode, function, byte and cycle counts
`timescale 1ns/1ps
`include "rmd_defines.svh"
module rmd_opcode_table import rmd_pkg::*; (
	input wire logic [7:0] opcode,
	output rmd_decode_t info
);
	logic [3:0] hi;
	logic [3:0] lo;
	logic [3:0] base;
	logic [3:0] extra;
	assign hi = opcode[7:4];
	assign lo = opcode[3:0];

	always_comb begin
		info = '0;
		info.mode = RMD_AM_NONE;
		info.alu = RMD_ALU_NONE;
		base = 4'h0;
		extra = 4'h0;
		if (opcode == `RMD_OP_UNSIGNED_PRODUCT) begin
			info.valid = 1'b1; // [RL1]
			info.mode = RMD_AM_INH;
			info.alu = RMD_ALU_UNSIGNED_PRODUCT;
			info.bytes = 2'h1;
			info.cycles = `RMD_UNSIGNED_PRODUCT_CYCLES;
		end else if (hi >= `RMD_MODE_IMM && !(hi == `RMD_MODE_IMM && (lo == `RMD_FN_STA ||
				lo == `RMD_FN_STX || lo == `RMD_FN_UNCONDITIONAL_JUMP ||
				lo == `RMD_FN_SUBROUTINE_CALL))) begin
			info.valid = 1'b1; // [RL4] [RL5] [RL6] [RL7] [RL8]
			unique case (hi)
				`RMD_MODE_IMM: begin info.mode = RMD_AM_IMM; info.bytes = 2'h2; base = 4'h2; end
				`RMD_MODE_DIR: begin info.mode = RMD_AM_DIR; info.bytes = 2'h2; base = 4'h3; end
				`RMD_MODE_EXT: begin info.mode = RMD_AM_EXT; info.bytes = 2'h3; base = 4'h4; end
				`RMD_MODE_IX: begin info.mode = RMD_AM_IX; info.bytes = 2'h1; base = 4'h3; end
				`RMD_MODE_IX1: begin info.mode = RMD_AM_IX1; info.bytes = 2'h2; base = 4'h4; end
				default: begin info.mode = RMD_AM_IX2; info.bytes = 2'h3; base = 4'h5; end
			endcase
			unique case (lo)
				`RMD_FN_SUB: info.alu = RMD_ALU_SUB;
				`RMD_FN_COMPARE_ACCUMULATOR: info.alu = RMD_ALU_COMPARE_ACCUMULATOR;
				`RMD_FN_SUBTRACT_WITH_BORROW: info.alu = RMD_ALU_SUBTRACT_WITH_BORROW;
				`RMD_FN_CPX: begin info.alu = RMD_ALU_COMPARE_ACCUMULATOR; info.use_x = 1'b1; end
				`RMD_FN_AND: info.alu = RMD_ALU_AND;
				`RMD_FN_BIT: info.alu = RMD_ALU_BIT;
				`RMD_FN_LDA: info.alu = RMD_ALU_LD;
				`RMD_FN_STA: begin info.alu = RMD_ALU_ST; extra = 4'h1; end
				`RMD_FN_EXCLUSIVE_OR: info.alu = RMD_ALU_EXCLUSIVE_OR;
				`RMD_FN_ADC: info.alu = RMD_ALU_ADC;
				`RMD_FN_ORA: info.alu = RMD_ALU_ORA;
				`RMD_FN_ADD: info.alu = RMD_ALU_ADD;
				`RMD_FN_UNCONDITIONAL_JUMP: info.alu = RMD_ALU_UNCONDITIONAL_JUMP;
				`RMD_FN_SUBROUTINE_CALL: info.alu = RMD_ALU_SUBROUTINE_CALL;
				`RMD_FN_LDX: begin info.alu = RMD_ALU_LD; info.use_x = 1'b1; end
				default: begin info.alu = RMD_ALU_ST; info.use_x = 1'b1; extra = 4'h1; end
			endcase
			// jumps take one cycle less, calls two more than the common timing
			if (lo == `RMD_FN_UNCONDITIONAL_JUMP)
				info.cycles = base - 4'h1; // [RL10]
			else if (lo == `RMD_FN_SUBROUTINE_CALL)
				info.cycles = base + 4'h2; // [RL10]
			else
				info.cycles = base + extra;
		end
	end
endmodule : rmd_opcode_table

// >>> shared/rmd_defines.svh
// constants for the register/memory and multiply decode block
`ifndef RMD_DEFINES_SVH
`define RMD_DEFINES_SVH
`define RMD_OP_UNSIGNED_PRODUCT 8'h42
`define RMD_MODE_IMM 4'ha
`define RMD_MODE_DIR 4'hb
`define RMD_MODE_EXT 4'hc
`define RMD_MODE_IX 4'hf
`define RMD_MODE_IX1 4'he
`define RMD_MODE_IX2 4'hd
`define RMD_FN_SUB 4'h0
`define RMD_FN_COMPARE_ACCUMULATOR 4'h1
`define RMD_FN_SUBTRACT_WITH_BORROW 4'h2
`define RMD_FN_CPX 4'h3
`define RMD_FN_AND 4'h4
`define RMD_FN_BIT 4'h5
`define RMD_FN_LDA 4'h6
`define RMD_FN_STA 4'h7
`define RMD_FN_EXCLUSIVE_OR 4'h8
`define RMD_FN_ADC 4'h9
`define RMD_FN_ORA 4'ha
`define RMD_FN_ADD 4'hb
`define RMD_FN_UNCONDITIONAL_JUMP 4'hc
`define RMD_FN_SUBROUTINE_CALL 4'hd
`define RMD_FN_LDX 4'he
`define RMD_FN_STX 4'hf
`define RMD_UNSIGNED_PRODUCT_CYCLES 4'hb
`define RMD_FLAG_H 4
`define RMD_FLAG_I 3
`define RMD_FLAG_N 2
`define RMD_FLAG_Z 1
`define RMD_FLAG_C 0
`define RMD_FLAGS_RESET 5'h08
`endif

// >>> shared/rmd_pkg.sv
// types shared by the register/memory and multiply decode block
package rmd_pkg;
	typedef enum logic [2:0] {
		RMD_AM_NONE, RMD_AM_INH, RMD_AM_IMM, RMD_AM_DIR,
		RMD_AM_EXT, RMD_AM_IX, RMD_AM_IX1, RMD_AM_IX2
	} rmd_mode_t;

	typedef enum logic [3:0] {
		RMD_ALU_NONE, RMD_ALU_ADD, RMD_ALU_ADC, RMD_ALU_SUB, RMD_ALU_SUBTRACT_WITH_BORROW,
		RMD_ALU_COMPARE_ACCUMULATOR, RMD_ALU_AND, RMD_ALU_BIT, RMD_ALU_ORA,
		RMD_ALU_EXCLUSIVE_OR, RMD_ALU_LD, RMD_ALU_ST, RMD_ALU_UNCONDITIONAL_JUMP,
		RMD_ALU_SUBROUTINE_CALL, RMD_ALU_UNSIGNED_PRODUCT
	} rmd_alu_t;

	typedef struct packed {
		logic valid;
		rmd_mode_t mode;
		rmd_alu_t alu;
		logic use_x;
		logic [1:0] bytes;
		logic [3:0] cycles;
	} rmd_decode_t;
endpackage : rmd_pkg
